// file: logic/ddr_row_capture.sv
// double-edge lane capture that pairs beats into whole storage rows
`timescale 1ns/100ps
module ddr_row_capture #(
    parameter int COLS = mirror_array_pkg::ARRAY_COLS,
    parameter int LANE_W = mirror_array_pkg::LANE_WIDTH,
    parameter int ROW_AW = 11
) (
    // clock and reset
    input wire logic i_mclk,
    input wire logic i_sys_rst,
    // link pins
    input wire logic [LANE_W-1:0] i_lane_rise,
    input wire logic [LANE_W-1:0] i_lane_fall,
    input wire logic i_lane_valid,
    input wire logic i_row_start,
    input wire logic [ROW_AW-1:0] i_row_addr,
    // row hand-off
    input wire logic i_accept,
    output logic o_row_valid,
    output logic [ROW_AW-1:0] o_row_addr,
    output logic [COLS-1:0] o_row_data,
    output logic o_load_ready
);
    localparam int BEAT_W = 2 * LANE_W;
    localparam int BEATS = COLS / BEAT_W;
    localparam int BI_W = $clog2(BEATS + 1);
    localparam int IN_W = 2 + ROW_AW + 2 * LANE_W;
    localparam logic [BI_W-1:0] LAST_BEAT = BI_W'(BEATS - 1);

    logic [IN_W-1:0] meta_reg;
    logic [IN_W-1:0] sync_reg;
    logic s_valid, s_start;
    logic [ROW_AW-1:0] s_addr;
    logic [BEAT_W-1:0] s_beat;
    logic [BI_W-1:0] idx_reg, idx_next, idx_use;
    logic [COLS-1:0] buf_reg, buf_next;
    logic [ROW_AW-1:0] addr_reg, addr_next;
    logic full_reg, full_next;
    logic ready_reg, ready_next;

    // ----------------------------------------------------------------
    // two-stage synchroniser on every link pin
    // ----------------------------------------------------------------
    always_ff @(posedge i_mclk or posedge i_sys_rst)
    begin
        if (i_sys_rst)
        begin
            meta_reg <= '0;
            sync_reg <= '0;
        end
        else
        begin
            meta_reg <= {i_lane_valid, i_row_start, i_row_addr, i_lane_fall, i_lane_rise};
            sync_reg <= meta_reg;
        end
    end

    assign {s_valid, s_start, s_addr, s_beat} = sync_reg; // rise half low, fall half high

    // beat pairing into the row buffer
    always_comb
    begin
        idx_next = idx_reg;
        buf_next = buf_reg;
        addr_next = addr_reg;
        full_next = full_reg;
        idx_use = s_start ? '0 : idx_reg;
        if (full_reg && i_accept)
            full_next = 1'b0;
        if (s_valid && !full_reg)
        begin
            buf_next[idx_use * BEAT_W +: BEAT_W] = s_beat;
            if (s_start)
                addr_next = s_addr;
            idx_next = idx_use + 1'b1;
            if (idx_use == LAST_BEAT)
            begin
                idx_next = '0;
                full_next = 1'b1;
            end
        end
        ready_next = !full_next;
    end

    // state registers
    always_ff @(posedge i_mclk or posedge i_sys_rst)
    begin
        if (i_sys_rst)
        begin
            idx_reg <= '0;
            buf_reg <= '0;
            addr_reg <= '0;
            full_reg <= 1'b0;
            ready_reg <= 1'b0;
        end
        else
        begin
            idx_reg <= idx_next;
            buf_reg <= buf_next;
            addr_reg <= addr_next;
            full_reg <= full_next;
            ready_reg <= ready_next;
        end
    end

    assign o_row_valid = full_reg;
    assign o_row_addr = addr_reg;
    assign o_row_data = buf_reg;
    assign o_load_ready = ready_reg;
endmodule

// file: logic/mirror_array_pkg.sv
// shared constants, states and carriers for the micromirror array update block
package mirror_array_pkg;

    // --------------------------------------------------------------
    // array geometry
    // --------------------------------------------------------------
    localparam int ARRAY_COLS = 2560;
    localparam int ARRAY_ROWS = 1600;
    localparam int TOTAL_MIRRORS = 4096000;
    localparam int LANE_WIDTH = 64;
    localparam int RESET_GROUPS = 16;
    localparam int GRP_W = 8;

    // --------------------------------------------------------------
    // timing
    // --------------------------------------------------------------
    localparam int CLK_PERIOD_PS = 8000;
    localparam int PULSE_MIN_NS = 80;
    localparam int PULSE_CYC = (PULSE_MIN_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int CNT_W = 16;

    // --------------------------------------------------------------
    // carriers and states
    // --------------------------------------------------------------
    typedef struct packed {
        logic all;
        logic [GRP_W-1:0] group;
    } pulse_cmd_s;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_COPY,
        ST_HOLD
    } update_state_e;

endpackage

// file: logic/mirror_array_update.sv
// storage cell array, mirror state latch and reset-group pulse sequencing
`timescale 1ns/100ps
module mirror_array_update #(
    parameter int COLS = mirror_array_pkg::ARRAY_COLS,
    parameter int ROWS = mirror_array_pkg::ARRAY_ROWS,
    parameter int LANE_W = mirror_array_pkg::LANE_WIDTH,
    parameter int GROUPS = mirror_array_pkg::RESET_GROUPS,
    parameter int PULSE_CYCLES = mirror_array_pkg::PULSE_CYC
) (
    // clock and reset
    input wire logic i_mclk,
    input wire logic i_sys_rst,
    // pattern link pins
    input wire logic [LANE_W-1:0] i_lane_rise,
    input wire logic [LANE_W-1:0] i_lane_fall,
    input wire logic i_lane_valid,
    input wire logic i_row_start,
    input wire logic [$clog2(ROWS)-1:0] i_row_addr,
    output logic o_load_ready,
    // pulse control pins
    input wire logic i_pulse_req,
    input wire logic i_pulse_all,
    input wire logic [mirror_array_pkg::GRP_W-1:0] i_pulse_group,
    output logic o_update_busy,
    output logic [GROUPS-1:0] o_mirror_group_reset_pulse,
    // mirror observation pins
    input wire logic i_park,
    input wire logic [$clog2(ROWS)-1:0] i_view_row,
    output logic o_landed,
    output logic [COLS-1:0] o_mirror_true,
    output logic [COLS-1:0] o_cell_inverted_output
);
    localparam int ROW_AW = $clog2(ROWS);
    localparam int RPG = ROWS / GROUPS;
    localparam int CNT_W = mirror_array_pkg::CNT_W;
    localparam logic [CNT_W-1:0] PULSE_LAST = CNT_W'(PULSE_CYCLES - 1);
    localparam logic [ROW_AW-1:0] ROW_LAST = ROW_AW'(ROWS - 1);
    localparam logic [ROW_AW-1:0] RPG_LAST = ROW_AW'(RPG - 1);
    localparam logic [CNT_W-1:0] BUSY_LIMIT = CNT_W'((ROWS > PULSE_CYCLES) ? ROWS : PULSE_CYCLES);

    // ----------------------------------------------------------------
    // storage: one cell and one landed mirror per position
    // ----------------------------------------------------------------
    logic [COLS-1:0] cell_mem [ROWS];
    logic [COLS-1:0] mirror_mem [ROWS];

    logic cap_valid;
    logic [ROW_AW-1:0] cap_addr;
    logic [COLS-1:0] cap_data;
    logic cap_ready;
    logic cmd_valid;
    mirror_array_pkg::pulse_cmd_s cmd;
    logic take;
    logic cell_we;
    logic mirror_we;

    mirror_array_pkg::update_state_e state_reg, state_next;
    logic [ROW_AW-1:0] row_reg, row_next;
    logic [ROW_AW-1:0] end_reg, end_next;
    logic [CNT_W-1:0] cnt_reg, cnt_next;
    logic [GROUPS-1:0] sel_reg, sel_next;
    logic [GROUPS-1:0] pulse_reg, pulse_next;
    logic busy_reg, busy_next;
    logic [1:0] park_sync_reg;
    logic [ROW_AW-1:0] view_meta_reg, view_sync_reg;
    logic landed_reg;
    logic [COLS-1:0] true_reg, inv_reg;

    // ----------------------------------------------------------------
    // link capture and pulse request
    // ----------------------------------------------------------------
    ddr_row_capture #(
        .COLS(COLS),
        .LANE_W(LANE_W),
        .ROW_AW(ROW_AW)
    ) u_capture (
        .i_mclk(i_mclk),
        .i_sys_rst(i_sys_rst),
        .i_lane_rise(i_lane_rise),
        .i_lane_fall(i_lane_fall),
        .i_lane_valid(i_lane_valid),
        .i_row_start(i_row_start),
        .i_row_addr(i_row_addr),
        .i_accept(cell_we),
        .o_row_valid(cap_valid),
        .o_row_addr(cap_addr),
        .o_row_data(cap_data),
        .o_load_ready(cap_ready)
    );

    mirror_pulse_request u_request (
        .i_mclk(i_mclk),
        .i_sys_rst(i_sys_rst),
        .i_pulse_req(i_pulse_req),
        .i_pulse_all(i_pulse_all),
        .i_pulse_group(i_pulse_group),
        .i_take(take),
        .o_cmd_valid(cmd_valid),
        .o_cmd(cmd)
    );

    // ----------------------------------------------------------------
    // pulse sequencer
    // ----------------------------------------------------------------
    // a pending pulse outranks a row write, so the write lands after it
    assign take = (state_reg == mirror_array_pkg::ST_IDLE) && cmd_valid;
    assign cell_we = (state_reg == mirror_array_pkg::ST_IDLE) && !cmd_valid && cap_valid;
    assign mirror_we = (state_reg == mirror_array_pkg::ST_COPY);

    // next state, copy row range and group select
    always_comb
    begin
        state_next = state_reg;
        row_next = row_reg;
        end_next = end_reg;
        cnt_next = cnt_reg;
        sel_next = sel_reg;
        unique case (state_reg)
            mirror_array_pkg::ST_IDLE:
            begin
                cnt_next = '0;
                if (take && (cmd.all || cmd.group < GROUPS))
                begin
                    state_next = mirror_array_pkg::ST_COPY;
                    if (cmd.all)
                    begin
                        sel_next = '1;
                        row_next = '0;
                        end_next = ROW_LAST;
                    end
                    else
                    begin
                        sel_next = GROUPS'(1) << cmd.group;
                        row_next = ROW_AW'(cmd.group * RPG);
                        end_next = ROW_AW'(cmd.group * RPG) + RPG_LAST;
                    end
                end
            end
            mirror_array_pkg::ST_COPY:
            begin
                cnt_next = cnt_reg + 1'b1;
                row_next = row_reg + 1'b1;
                if (row_reg == end_reg)
                    state_next = (cnt_reg >= PULSE_LAST) ? mirror_array_pkg::ST_IDLE
                                                         : mirror_array_pkg::ST_HOLD;
            end
            mirror_array_pkg::ST_HOLD:
            begin
                cnt_next = cnt_reg + 1'b1;
                if (cnt_reg >= PULSE_LAST)
                    state_next = mirror_array_pkg::ST_IDLE;
            end
        endcase
        pulse_next = (state_next == mirror_array_pkg::ST_IDLE) ? '0 : sel_next;
        busy_next = (state_next != mirror_array_pkg::ST_IDLE);
    end

    always_ff @(posedge i_mclk or posedge i_sys_rst)
    begin
        if (i_sys_rst)
        begin
            state_reg <= mirror_array_pkg::ST_IDLE;
            row_reg <= '0;
            end_reg <= '0;
            cnt_reg <= '0;
            sel_reg <= '0;
            pulse_reg <= '0;
            busy_reg <= 1'b0;
        end
        else
        begin
            state_reg <= state_next;
            row_reg <= row_next;
            end_reg <= end_next;
            cnt_reg <= cnt_next;
            sel_reg <= sel_next;
            pulse_reg <= pulse_next;
            busy_reg <= busy_next;
        end
    end

    // ----------------------------------------------------------------
    // memory writes: cells from the link, mirrors from cells
    // ----------------------------------------------------------------
    always_ff @(posedge i_mclk)
    begin
        if (cell_we && cap_addr <= ROW_LAST)
            cell_mem[cap_addr] <= cap_data;
        if (mirror_we)
            mirror_mem[row_reg] <= cell_mem[row_reg]; // 1 lands on, 0 lands off
    end

    // ----------------------------------------------------------------
    // observation: electrode pair of the chosen row
    // ----------------------------------------------------------------
    always_ff @(posedge i_mclk or posedge i_sys_rst)
    begin
        if (i_sys_rst)
        begin
            park_sync_reg <= 2'h3;
            view_meta_reg <= '0;
            view_sync_reg <= '0;
            landed_reg <= 1'b0;
            true_reg <= '0;
            inv_reg <= '0;
        end
        else
        begin
            park_sync_reg <= {park_sync_reg[0], i_park};
            view_meta_reg <= i_view_row;
            view_sync_reg <= view_meta_reg;
            landed_reg <= !park_sync_reg[1];
            true_reg <= park_sync_reg[1] ? '0 : mirror_mem[view_sync_reg];
            inv_reg <= park_sync_reg[1] ? '0 : ~mirror_mem[view_sync_reg];
        end
    end

    assign o_load_ready = cap_ready;
    assign o_update_busy = busy_reg;
    assign o_mirror_group_reset_pulse = pulse_reg;
    assign o_landed = landed_reg;
    assign o_mirror_true = true_reg;
    assign o_cell_inverted_output = inv_reg;

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    logic chk_reg;
    logic [ROW_AW-1:0] chk_row_reg;
    logic [COLS-1:0] chk_data_reg;
    logic [CNT_W-1:0] busy_cyc_reg; // cycles spent busy in the current update

    always_ff @(posedge i_mclk or posedge i_sys_rst)
    begin
        if (i_sys_rst)
        begin
            chk_reg <= 1'b0;
            chk_row_reg <= '0;
            chk_data_reg <= '0;
            busy_cyc_reg <= '0;
        end
        else
        begin
            chk_reg <= mirror_we;
            chk_row_reg <= row_reg;
            chk_data_reg <= cell_mem[row_reg];
            busy_cyc_reg <= busy_reg ? busy_cyc_reg + 1'b1 : '0;
        end
    end

    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (i_sys_rst);

    property p_pulse_len;
        $rose(|o_mirror_group_reset_pulse) |-> (|o_mirror_group_reset_pulse) [*8];
    endproperty
    a_pulse_len: assert property (p_pulse_len) else $error("pulse too short");

    property p_no_write_busy;
        cap_valid && (cmd_valid || (state_reg != mirror_array_pkg::ST_IDLE)) |=> cap_valid;
    endproperty
    a_no_write_busy: assert property (p_no_write_busy) else $error("write during pulse");

    property p_mirror_only_pulse;
        mirror_we |-> (|o_mirror_group_reset_pulse);
    endproperty
    a_mirror_only_pulse: assert property (p_mirror_only_pulse) else $error("move w/o pulse");

    property p_copy_value;
        chk_reg |-> mirror_mem[chk_row_reg] == chk_data_reg;
    endproperty
    a_copy_value: assert property (p_copy_value) else $error("mirror not cell value");

    property p_true_inv;
        o_landed |-> (o_cell_inverted_output == ~o_mirror_true);
    endproperty
    a_true_inv: assert property (p_true_inv) else $error("electrode pair mismatch");

    property p_park;
        !o_landed |-> (o_mirror_true == '0) && (o_cell_inverted_output == '0);
    endproperty
    a_park: assert property (p_park) else $error("parked array driven");

    property p_order;
        take && cmd.all |=> (state_reg == mirror_array_pkg::ST_COPY) && (row_reg == '0);
    endproperty
    a_order: assert property (p_order) else $error("pulse did not start copy");

    property p_group;
        (state_reg != mirror_array_pkg::ST_IDLE) |-> (o_mirror_group_reset_pulse == sel_reg);
    endproperty
    a_group: assert property (p_group) else $error("wrong group pulsed");

    property p_busy_ends;
        busy_cyc_reg <= BUSY_LIMIT;
    endproperty
    a_busy_ends: assert property (p_busy_ends) else $error("update never ends");

    property p_cv_all;
        take && cmd.all;
    endproperty
    c_cv_all: cover property (p_cv_all);

    property p_cv_group;
        take && !cmd.all ##1 mirror_we;
    endproperty
    c_cv_group: cover property (p_cv_group);

    property p_cv_write_then_pulse;
        cell_we ##[1:50] take;
    endproperty
    c_cv_write_then_pulse: cover property (p_cv_write_then_pulse);
endmodule

// file: logic/mirror_pulse_request.sv
// synchronises the controller's pulse request and holds it as a command
`timescale 1ns/100ps
module mirror_pulse_request (
    // clock and reset
    input wire logic i_mclk,
    input wire logic i_sys_rst,
    // controller pins
    input wire logic i_pulse_req,
    input wire logic i_pulse_all,
    input wire logic [mirror_array_pkg::GRP_W-1:0] i_pulse_group,
    // command hand-off
    input wire logic i_take,
    output logic o_cmd_valid,
    output mirror_array_pkg::pulse_cmd_s o_cmd
);
    localparam int W = mirror_array_pkg::GRP_W + 2;

    logic [W-1:0] meta_reg, sync_reg;
    logic prev_reg;
    logic pend_reg, pend_next;
    mirror_array_pkg::pulse_cmd_s cmd_reg, cmd_next;
    logic req_edge;

    // ----------------------------------------------------------------
    // synchroniser and edge detect
    // ----------------------------------------------------------------
    always_ff @(posedge i_mclk or posedge i_sys_rst)
    begin
        if (i_sys_rst)
        begin
            meta_reg <= '0;
            sync_reg <= '0;
            prev_reg <= 1'b0;
        end
        else
        begin
            meta_reg <= {i_pulse_req, i_pulse_all, i_pulse_group};
            sync_reg <= meta_reg;
            prev_reg <= sync_reg[W-1];
        end
    end

    assign req_edge = sync_reg[W-1] && !prev_reg;

    // a new request in the take cycle stays pending
    always_comb
    begin
        pend_next = pend_reg;
        cmd_next = cmd_reg;
        if (i_take)
            pend_next = 1'b0;
        if (req_edge)
        begin
            pend_next = 1'b1;
            cmd_next = sync_reg[W-2:0];
        end
    end

    always_ff @(posedge i_mclk or posedge i_sys_rst)
    begin
        if (i_sys_rst)
        begin
            pend_reg <= 1'b0;
            cmd_reg <= '0;
        end
        else
        begin
            pend_reg <= pend_next;
            cmd_reg <= cmd_next;
        end
    end

    assign o_cmd_valid = pend_reg;
    assign o_cmd = cmd_reg;
endmodule

// file: verification/mirror_array_update_tb.sv
// self-checking bench for the mirror array update block
`timescale 1ns/100ps
module mirror_array_update_tb;
    localparam int COLS = 256;
    localparam int ROWS = 32;
    localparam int LANE_W = 64;
    localparam int GROUPS = 4;
    localparam int PCYC = 2;
    localparam int GROW = ROWS / GROUPS;
    localparam int GLEN = (GROW > PCYC) ? GROW : PCYC;
    localparam int ALEN = (ROWS > PCYC) ? ROWS : PCYC;
    localparam logic [COLS-1:0] P1 = {4{64'h0f3c_a5e1_7700_ff12}};
    localparam logic [COLS-1:0] P2 = {4{64'hc381_5a5a_00ff_e7d0}};

    logic i_mclk = 1'b0;
    logic i_sys_rst = 1'b1;
    logic [LANE_W-1:0] lane_rise;
    logic [LANE_W-1:0] lane_fall;
    logic lane_valid;
    logic row_start;
    logic [4:0] row_addr;
    logic load_ready;
    logic pulse_req;
    logic pulse_all;
    logic [mirror_array_pkg::GRP_W-1:0] pulse_group;
    logic busy;
    logic [GROUPS-1:0] pulse;
    logic park = 1'b1; // parked until every mirror holds a written value
    logic [4:0] view_row = '0;
    logic landed;
    logic [COLS-1:0] mtrue;
    logic [COLS-1:0] minv;
    logic fault;
    int n_mismatch = 0;
    int cmp_count = 0;

    // 125 MHz clock
    always #4 i_mclk = ~i_mclk;

    mirror_array_update #(.COLS(COLS), .ROWS(ROWS), .LANE_W(LANE_W), .GROUPS(GROUPS),
        .PULSE_CYCLES(PCYC)) uut (.i_mclk(i_mclk), .i_sys_rst(i_sys_rst),
        .i_lane_rise(lane_rise), .i_lane_fall(lane_fall), .i_lane_valid(lane_valid),
        .i_row_start(row_start), .i_row_addr(row_addr), .o_load_ready(load_ready),
        .i_pulse_req(pulse_req), .i_pulse_all(pulse_all), .i_pulse_group(pulse_group),
        .o_update_busy(busy), .o_mirror_group_reset_pulse(pulse), .i_park(park),
        .i_view_row(view_row), .o_landed(landed), .o_mirror_true(mtrue),
        .o_cell_inverted_output(minv));

    pattern_ctl_model #(.COLS(COLS), .LANE_W(LANE_W), .AW(5)) ctl (.i_mclk(i_mclk),
        .i_load_ready(load_ready), .o_lane_rise(lane_rise), .o_lane_fall(lane_fall),
        .o_lane_valid(lane_valid), .o_row_start(row_start), .o_row_addr(row_addr),
        .o_pulse_req(pulse_req), .o_pulse_all(pulse_all), .o_pulse_group(pulse_group),
        .o_fault(fault));

    // --------------------------------------------------------------
    // shared tasks
    // --------------------------------------------------------------
    task automatic check(input string nm, input logic [COLS-1:0] seen,
        input logic [COLS-1:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("unexpected %s: expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic results();
        $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
        if (n_mismatch == 0 && cmp_count > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    // find the pulse, then time it and check which lines carried it
    task automatic measure(input logic [GROUPS-1:0] lines, input int len);
        int n;
        logic [GROUPS-1:0] seen;
        n = 0;
        while (pulse === '0 && n < 60)
        begin
            @(posedge i_mclk);
            #1;
            n++;
        end
        check("pulse start", n < 60, 1'b1);
        if (n >= 60)
            results();
        seen = pulse;
        check("busy in pulse", busy, 1'b1);
        n = 0;
        while (pulse !== '0 && n < 100)
        begin
            n++;
            @(posedge i_mclk);
            #1;
        end
        check("pulse lines", seen, lines);
        check("pulse length", n, len);
        check("busy after", busy, 1'b0);
    endtask

    task automatic fire(input logic all, input logic [7:0] g, input logic [GROUPS-1:0] lines,
        input int len);
        fork
            ctl.request_pulse(all, g);
            measure(lines, len);
        join
    endtask

    task automatic view(input logic [4:0] r, input logic [COLS-1:0] exp);
        view_row = r;
        repeat (5) @(posedge i_mclk);
        #1;
        check("landed", landed, 1'b1);
        check("mirror true", mtrue, exp);
        check("mirror inverted", minv, ~exp);
    endtask

    // --------------------------------------------------------------
    // scenarios
    // --------------------------------------------------------------
    task automatic t_whole();
        for (int r = 0; r < ROWS; r++)
            ctl.load_row(5'(r), (r == ROWS - 1) ? ~P1 : P1);
        fire(1'b1, 8'h00, '1, ALEN);
        park = 1'b0;
        view(5'd3, P1);
        view(5'(ROWS - 1), ~P1);
    endtask

    task automatic t_hidden();
        ctl.load_row(5'd3, P2);
        view(5'd3, P1);
        fire(1'b0, 8'h01, 4'h2, GLEN);
        view(5'd3, P1);
        fire(1'b0, 8'h00, 4'h1, GLEN);
        view(5'd3, P2);
    endtask

    task automatic t_groups();
        logic [4:0] r;
        for (int g = 0; g < GROUPS; g++)
        begin
            r = 5'(g * GROW + GROW - 1);
            ctl.load_row(r, P1 ^ COLS'(g));
            fire(1'b0, 8'(g), GROUPS'(1 << g), GLEN);
            view(r, P1 ^ COLS'(g));
        end
    endtask

    task automatic t_bad_group();
        int hits;
        hits = 0;
        fork
            ctl.request_pulse(1'b0, 8'(GROUPS));
            repeat (40)
            begin
                @(posedge i_mclk);
                #1;
                hits += (pulse !== '0);
            end
        join
        check("invalid group pulse", hits, 0);
    endtask

    task automatic t_park();
        park = 1'b1;
        repeat (5) @(posedge i_mclk);
        #1;
        check("parked landed", landed, 1'b0);
        check("parked true", mtrue, '0);
        check("parked inverted", minv, '0);
        park = 1'b0;
        view(5'd3, P2);
    endtask

    // reset, scenarios, verdict
    initial
    begin
        repeat (4) @(posedge i_mclk);
        #1;
        check("reset ready", load_ready, 1'b0);
        check("reset pulse", pulse, '0);
        check("reset landed", landed, 1'b0);
        i_sys_rst = 1'b0;
        t_whole();
        t_hidden();
        t_groups();
        t_bad_group();
        t_park();
        check("controller stall", fault, 1'b0);
        results();
    end
endmodule

// file: verification/pattern_ctl_model.sv
// controller-side model that streams rows and asks for mirror clocking pulses
`timescale 1ns/100ps
module pattern_ctl_model #(
    parameter int COLS = 256,
    parameter int LANE_W = 64,
    parameter int AW = 5
) (
    // clock and device status
    input wire logic i_mclk,
    input wire logic i_load_ready,
    // pins toward the device
    output logic [LANE_W-1:0] o_lane_rise,
    output logic [LANE_W-1:0] o_lane_fall,
    output logic o_lane_valid,
    output logic o_row_start,
    output logic [AW-1:0] o_row_addr,
    output logic o_pulse_req,
    output logic o_pulse_all,
    output logic [mirror_array_pkg::GRP_W-1:0] o_pulse_group,
    // set when the device never became ready
    output logic o_fault
);
    localparam int BEATS = COLS / (2 * LANE_W);

    // --------------------------------------------------------------
    // idle pin levels
    // --------------------------------------------------------------
    initial
    begin
        o_lane_rise = '0;
        o_lane_fall = '1;
        o_lane_valid = 1'b0;
        o_row_start = 1'b0;
        o_row_addr = '0;
        o_pulse_req = 1'b0;
        o_pulse_all = 1'b0;
        o_pulse_group = '0;
        o_fault = 1'b0;
    end

    // bounded wait for room in the row buffer
    task automatic wait_ready();
        int n;
        n = 0;
        while (i_load_ready !== 1'b1 && n < 300)
        begin
            @(posedge i_mclk);
            #1;
            n++;
        end
        if (n >= 300)
            o_fault = 1'b1;
    endtask

    // stream one binary row as back-to-back double-edge beats
    task automatic load_row(input logic [AW-1:0] a, input logic [COLS-1:0] d);
        @(posedge i_mclk);
        #1;
        wait_ready();
        for (int k = 0; k < BEATS; k++)
        begin
            o_lane_rise = d[k*2*LANE_W +: LANE_W];
            o_lane_fall = d[k*2*LANE_W+LANE_W +: LANE_W];
            o_lane_valid = 1'b1;
            o_row_start = (k == 0);
            o_row_addr = a;
            @(posedge i_mclk);
            #1;
        end
        // released lanes show the inverse of the last beat, not a stale copy
        o_lane_valid = 1'b0;
        o_row_start = 1'b0;
        o_lane_rise = ~o_lane_rise;
        o_lane_fall = ~o_lane_fall;
        repeat (6) @(posedge i_mclk);
        #1;
        wait_ready();
    endtask

    // level request; the device makes the pulse itself
    task automatic request_pulse(input logic all, input logic [7:0] grp);
        @(posedge i_mclk);
        #1;
        o_pulse_all = all;
        o_pulse_group = grp;
        o_pulse_req = 1'b1;
        repeat (4) @(posedge i_mclk);
        #1;
        o_pulse_req = 1'b0;
        repeat (4) @(posedge i_mclk);
        #1;
    endtask
endmodule
